/* File: hw/lcdcd_decoder.sv */
module lcdcd_decoder
    import lcdcd_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_byte,
    input wire logic i_data_wr,
    input wire logic i_data_rd,
    output logic [5:0] o_start_line,
    output logic [7:0] o_col_addr,
    output logic [3:0] o_page_addr,
    output logic o_com_reverse,
    output logic [2:0] o_power_ctrl,
    output logic o_follower_on,
    output logic o_regulator_on,
    output logic o_booster_on,
    output logic [2:0] o_regulator_resistor_ratio,
    output logic [5:0] o_contrast,
    output logic o_ind_enable,
    output logic [1:0] o_ind_state,
    output logic o_rmw_mode,
    output logic o_test_mode,
    output logic o_cmd_pending
);
    typedef struct packed {
        lcdcd_mode_t mode;
        logic [5:0] line;
        logic [3:0] page;
        logic com_rev;
        logic [2:0] power;
        logic [2:0] ratio;
        logic [5:0] contrast;
        logic ind_en;
        logic [1:0] ind;
        logic test;
    } lcdcd_state_t;

    lcdcd_state_t st_ff;
    lcdcd_state_t nxt_st;

    // Masked opcode match, shared by every range decode
    function automatic logic hit(input logic [7:0] b, input logic [7:0] code,
                                 input logic [7:0] mask);
        return (b & mask) == code;
    endfunction

    logic idle_cmd;
    logic col_clear;
    logic col_hi;
    logic col_lo;
    logic rmw_enter;
    logic rmw_end;

    // Column strobes only fire for bytes decoded outside a pending sequence
    assign idle_cmd = i_cmd_valid && (st_ff.mode == LCDCD_IDLE);
    assign col_clear = idle_cmd && (i_cmd_byte == CMD_SOFT_RESET);
    assign col_hi = idle_cmd && hit(i_cmd_byte, CMD_COL_HI, MASK_COL_HI);
    assign col_lo = idle_cmd && hit(i_cmd_byte, CMD_COL_LO, MASK_COL_LO);
    assign rmw_enter = idle_cmd && (i_cmd_byte == CMD_RMW_ENTER);
    assign rmw_end = idle_cmd && (i_cmd_byte == CMD_RMW_END);

    lcdcd_col_counter u_col (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_clear(col_clear),
        .i_load_hi(col_hi),
        .i_load_lo(col_lo),
        .i_nibble(i_cmd_byte[3:0]),
        .i_rmw_enter(rmw_enter),
        .i_rmw_end(rmw_end),
        .i_data_wr(i_data_wr),
        .i_data_rd(i_data_rd),
        .o_col(o_col_addr),
        .o_rmw(o_rmw_mode)
    );

    // Command decode; pending states swallow the next byte whatever it is
    always_comb begin
        nxt_st = st_ff;
        if (i_cmd_valid) begin
            unique case (st_ff.mode)
                LCDCD_WAIT_VOL: begin
                    nxt_st.contrast = i_cmd_byte[5:0];
                    nxt_st.mode = LCDCD_IDLE;
                end
                LCDCD_WAIT_IND: begin
                    nxt_st.ind = i_cmd_byte[1:0];
                    nxt_st.mode = LCDCD_IDLE;
                end
                LCDCD_IDLE: begin
                    if (i_cmd_byte == CMD_SOFT_RESET) begin
                        // Power field is kept on purpose: supplies stay up
                        // Display memory lives outside; nothing here writes it
                        nxt_st.line = LINE_RST;
                        nxt_st.page = PAGE_RST;
                        nxt_st.com_rev = 1'b0;
                        nxt_st.ratio = RATIO_RST;
                        nxt_st.contrast = CONTRAST_RST;
                        nxt_st.ind_en = 1'b0;
                        nxt_st.ind = IND_RST;
                        nxt_st.test = 1'b0;
                    end else if (i_cmd_byte == CMD_VOL_MODE) begin
                        nxt_st.mode = LCDCD_WAIT_VOL;
                    end else if (i_cmd_byte == CMD_IND_OFF) begin
                        nxt_st.ind_en = 1'b0;
                    end else if (i_cmd_byte == CMD_IND_ON) begin
                        nxt_st.ind_en = 1'b1;
                        nxt_st.mode = LCDCD_WAIT_IND;
                    end else if (hit(i_cmd_byte, CMD_COM_DIR, MASK_COM_DIR)) begin
                        nxt_st.com_rev = i_cmd_byte[COM_DIR_BIT];
                    end else if (hit(i_cmd_byte, CMD_POWER, MASK_POWER)) begin
                        nxt_st.power = i_cmd_byte[2:0];
                    end else if (hit(i_cmd_byte, CMD_RATIO, MASK_RATIO)) begin
                        nxt_st.ratio = i_cmd_byte[2:0];
                    end else if (hit(i_cmd_byte, CMD_TEST, MASK_TEST)) begin
                        nxt_st.test = 1'b1;
                    end else if (hit(i_cmd_byte, CMD_START_LINE, MASK_START_LINE)) begin
                        nxt_st.line = i_cmd_byte[5:0];
                    end else if (hit(i_cmd_byte, CMD_PAGE, MASK_PAGE)) begin
                        nxt_st.page = i_cmd_byte[3:0];
                    end
                end
                default: begin
                    nxt_st.mode = LCDCD_IDLE;
                end
            endcase
        end
    end

    // Hard reset alone returns the power field to off
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '{mode: LCDCD_IDLE, line: LINE_RST, page: PAGE_RST, com_rev: 1'b0,
                       power: POWER_RST, ratio: RATIO_RST, contrast: CONTRAST_RST,
                       ind_en: 1'b0, ind: IND_RST, test: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // All outputs but column address and RMW flag straight from the state register; pending decoded from its mode
    assign o_start_line = st_ff.line;
    assign o_page_addr = st_ff.page;
    assign o_com_reverse = st_ff.com_rev;
    assign o_power_ctrl = st_ff.power;
    assign o_follower_on = st_ff.power[PWR_FOLLOWER_BIT];
    assign o_regulator_on = st_ff.power[PWR_REGULATOR_BIT];
    assign o_booster_on = st_ff.power[PWR_BOOSTER_BIT];
    assign o_regulator_resistor_ratio = st_ff.ratio;
    assign o_contrast = st_ff.contrast;
    assign o_ind_enable = st_ff.ind_en;
    assign o_ind_state = st_ff.ind;
    assign o_test_mode = st_ff.test;
    assign o_cmd_pending = (st_ff.mode != LCDCD_IDLE);
endmodule

/* File: hw/lcdcd_pkg.sv */
package lcdcd_pkg;
    // Command codes and masks
    localparam logic [7:0] CMD_RMW_ENTER = 8'he0;
    localparam logic [7:0] CMD_RMW_END = 8'hee;
    localparam logic [7:0] CMD_SOFT_RESET = 8'he2;
    localparam logic [7:0] CMD_VOL_MODE = 8'h81;
    localparam logic [7:0] CMD_IND_OFF = 8'hac;
    localparam logic [7:0] CMD_IND_ON = 8'had;
    localparam logic [7:0] CMD_COM_DIR = 8'hc0;
    localparam logic [7:0] MASK_COM_DIR = 8'hf0;
    localparam logic [7:0] CMD_POWER = 8'h28;
    localparam logic [7:0] MASK_POWER = 8'hf8;
    localparam logic [7:0] CMD_RATIO = 8'h20;
    localparam logic [7:0] MASK_RATIO = 8'hf8;
    localparam logic [7:0] CMD_TEST = 8'hf0;
    localparam logic [7:0] MASK_TEST = 8'hf0;
    localparam logic [7:0] CMD_START_LINE = 8'h40;
    localparam logic [7:0] MASK_START_LINE = 8'hc0;
    localparam logic [7:0] CMD_PAGE = 8'hb0;
    localparam logic [7:0] MASK_PAGE = 8'hf0;
    localparam logic [7:0] CMD_COL_HI = 8'h10;
    localparam logic [7:0] MASK_COL_HI = 8'hf0;
    localparam logic [7:0] CMD_COL_LO = 8'h00;
    localparam logic [7:0] MASK_COL_LO = 8'hf0;
    // Field positions
    localparam int COM_DIR_BIT = 3;
    localparam int PWR_FOLLOWER_BIT = 0;
    localparam int PWR_REGULATOR_BIT = 1;
    localparam int PWR_BOOSTER_BIT = 2;
    // Values after reset, and the last column
    localparam logic [5:0] CONTRAST_RST = 6'h20;
    localparam logic [2:0] RATIO_RST = 3'h0;
    localparam logic [2:0] POWER_RST = 3'h0;
    localparam logic [1:0] IND_RST = 2'h0;
    localparam logic [7:0] COL_RST = 8'h00;
    localparam logic [3:0] PAGE_RST = 4'h0;
    localparam logic [5:0] LINE_RST = 6'h00;
    localparam logic [7:0] COL_LAST = 8'h83;

    typedef enum logic [1:0] {
        LCDCD_IDLE,
        LCDCD_WAIT_VOL,
        LCDCD_WAIT_IND
    } lcdcd_mode_t;
endpackage

/* File: hw/lcdcd_col_counter.sv */
module lcdcd_col_counter
    import lcdcd_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_load_hi,
    input wire logic i_load_lo,
    input wire logic [3:0] i_nibble,
    input wire logic i_rmw_enter,
    input wire logic i_rmw_end,
    input wire logic i_data_wr,
    input wire logic i_data_rd,
    output logic [7:0] o_col,
    output logic o_rmw
);
    typedef struct packed {
        logic [7:0] col;
        logic [7:0] saved;
        logic rmw;
    } lcdcd_col_state_t;

    lcdcd_col_state_t st_ff;
    lcdcd_col_state_t nxt_st;

    // Stop at the last column instead of wrapping
    function automatic logic [7:0] step(input logic [7:0] c);
        return (c == COL_LAST) ? c : c + 8'h01;
    endfunction

    // Clear wins over everything; data access only when no clear, column or RMW strobe
    always_comb begin
        nxt_st = st_ff;
        if (i_clear) begin
            nxt_st.col = COL_RST;
            nxt_st.rmw = 1'b0;
        end else if (i_load_hi) begin
            nxt_st.col = {i_nibble, st_ff.col[3:0]};
        end else if (i_load_lo) begin
            nxt_st.col = {st_ff.col[7:4], i_nibble};
        end else if (i_rmw_enter) begin
            nxt_st.rmw = 1'b1;
            nxt_st.saved = st_ff.col;
        end else if (i_rmw_end) begin
            if (st_ff.rmw) begin
                nxt_st.col = st_ff.saved;
            end
            nxt_st.rmw = 1'b0;
        end else if (i_data_wr) begin
            nxt_st.col = step(st_ff.col);
        end else if (i_data_rd && !st_ff.rmw) begin
            nxt_st.col = step(st_ff.col);
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '{col: COL_RST, saved: COL_RST, rmw: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_col = st_ff.col;
    assign o_rmw = st_ff.rmw;
endmodule

/* File: tb/lcdcd_host_model.sv */
// Host side: writes command bytes and pulses the data strobes
module lcdcd_host_model (
    input wire logic i_ref_clk,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_byte,
    output logic o_data_wr,
    output logic o_data_rd
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_byte = 8'h00;
        o_data_wr = 1'b0;
        o_data_rd = 1'b0;
    end

    // One byte per strobe; the byte is scrambled once unqualified
    task automatic send(input logic [7:0] b);
        @(posedge i_ref_clk);
        #2 o_cmd_valid = 1'b1;
        o_cmd_byte = b;
        @(posedge i_ref_clk);
        #2 o_cmd_valid = 1'b0;
        o_cmd_byte = ~b;
    endtask

    // Display data strobes, one cycle each
    task automatic wr();
        @(posedge i_ref_clk);
        #2 o_data_wr = 1'b1;
        @(posedge i_ref_clk);
        #2 o_data_wr = 1'b0;
    endtask

    task automatic rd();
        @(posedge i_ref_clk);
        #2 o_data_rd = 1'b1;
        @(posedge i_ref_clk);
        #2 o_data_rd = 1'b0;
    endtask
endmodule

/* File: tb/lcdcd_decoder_asserts.sv */
module lcdcd_decoder_chk
    import lcdcd_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_byte,
    input wire logic i_data_rd,
    input wire logic [7:0] o_col_addr,
    input wire logic o_com_reverse,
    input wire logic [2:0] o_power_ctrl,
    input wire logic o_follower_on,
    input wire logic o_booster_on,
    input wire logic [2:0] o_regulator_resistor_ratio,
    input wire logic [5:0] o_contrast,
    input wire logic o_ind_enable,
    input wire logic [1:0] o_ind_state,
    input wire logic o_rmw_mode,
    input wire logic o_test_mode,
    input wire logic o_cmd_pending
);
    logic vol_wait_ff;
    logic take;
    // A first byte only counts when no second byte is awaited
    assign take = i_cmd_valid && !o_cmd_pending;

    // Pending state alone cannot tell contrast from indicator
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            vol_wait_ff <= 1'b0;
        end else if (i_cmd_valid) begin
            vol_wait_ff <= take && i_cmd_byte == 8'h81;
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_vol_pend_set: assert property (take && i_cmd_byte == 8'h81 |=> o_cmd_pending)
        else $error("contrast pending not entered");
    a_vol_load: assert property (i_cmd_valid && o_cmd_pending && vol_wait_ff |=>
        o_contrast == $past(i_cmd_byte[5:0]) && !o_cmd_pending)
        else $error("contrast byte not loaded");
    a_ind_load: assert property (i_cmd_valid && o_cmd_pending && !vol_wait_ff |=>
        o_ind_state == $past(i_cmd_byte[1:0]) && o_ind_enable && !o_cmd_pending)
        else $error("indicator byte not loaded");
    a_ind_hold: assert property (!i_cmd_valid || (take && i_cmd_byte[7:4] != 4'ha &&
        i_cmd_byte != 8'he2) |=> $stable(o_ind_state) && $stable(o_ind_enable))
        else $error("indicator changed by other command");
    a_com_dir: assert property (take && i_cmd_byte[7:4] == 4'hc |=>
        o_com_reverse == $past(i_cmd_byte[3]))
        else $error("scan direction wrong");
    a_power_load: assert property (take && i_cmd_byte[7:3] == 5'h05 |=>
        o_power_ctrl == $past(i_cmd_byte[2:0]) && o_follower_on == o_power_ctrl[0] &&
        o_booster_on == o_power_ctrl[2])
        else $error("power field wrong");
    a_ratio_load: assert property (take && i_cmd_byte[7:3] == 5'h04 |=>
        o_regulator_resistor_ratio == $past(i_cmd_byte[2:0]))
        else $error("ratio wrong");
    a_soft_reset: assert property (take && i_cmd_byte == 8'he2 |=> o_contrast == 6'h20 &&
        o_regulator_resistor_ratio == 3'h0 && !o_test_mode && !o_rmw_mode &&
        o_power_ctrl == $past(o_power_ctrl))
        else $error("software reset wrong");
    a_rmw_rd_hold: assert property (o_rmw_mode && i_data_rd && !i_cmd_valid |=>
        $stable(o_col_addr))
        else $error("read advanced column in rmw");
endmodule

/* File: tb/lcdcd_decoder_bench.sv */
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end

module lcdcd_decoder_bench import lcdcd_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic cmd_valid, data_wr, data_rd, com_rev, fol, reg_on, boost, ind_en, rmw, tst, pend;
    logic [7:0] cmd_byte, col;
    logic [5:0] contrast;
    logic [2:0] power, ratio;
    logic [1:0] ind_state;
    int failures = 0;
    int check_count = 0;

    initial begin
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    lcdcd_host_model host_u (.i_ref_clk(i_ref_clk), .o_cmd_valid(cmd_valid),
        .o_cmd_byte(cmd_byte), .o_data_wr(data_wr), .o_data_rd(data_rd));

    lcdcd_decoder dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd_valid(cmd_valid),
        .i_cmd_byte(cmd_byte), .i_data_wr(data_wr), .i_data_rd(data_rd), .o_start_line(),
        .o_col_addr(col), .o_page_addr(), .o_com_reverse(com_rev), .o_power_ctrl(power),
        .o_follower_on(fol), .o_regulator_on(reg_on), .o_booster_on(boost),
        .o_regulator_resistor_ratio(ratio), .o_contrast(contrast), .o_ind_enable(ind_en),
        .o_ind_state(ind_state), .o_rmw_mode(rmw), .o_test_mode(tst), .o_cmd_pending(pend));

    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run is about 125 cycles; this is far beyond it
    initial begin
        #50us;
        failures++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge i_ref_clk);
        #2 i_rst = 1'b0;
        `CHK(contrast, CONTRAST_RST)
        // Every power and ratio code, scan direction codes c0 to c7 and cf
        for (int i = 0; i < 8; i++) begin
            host_u.send(CMD_POWER | 8'(i));
            `CHK(power, 3'(i))
            `CHK({boost, reg_on, fol}, 3'(i))
            host_u.send(CMD_RATIO | 8'(i));
            `CHK(ratio, 3'(i))
            host_u.send(CMD_COM_DIR | 8'(i));
            `CHK(com_rev, 1'b0)
        end
        host_u.send(CMD_COM_DIR | 8'h0f);
        `CHK(com_rev, 1'b1)
        host_u.send(CMD_COM_DIR | 8'h07);
        `CHK(com_rev, 1'b0)
        // Indicator on with each state, then off
        for (int i = 0; i < 4; i++) begin
            host_u.send(CMD_IND_ON);
            `CHK(pend, 1'b1)
            host_u.send(8'(i));
            `CHK({ind_en, ind_state, pend}, {1'b1, 2'(i), 1'b0})
        end
        host_u.send(CMD_IND_OFF);
        `CHK(ind_en, 1'b0)
        // Contrast, including a stray reset code taken as data
        host_u.send(CMD_VOL_MODE);
        host_u.send(8'hff);
        `CHK(contrast, 6'h3f)
        host_u.send(CMD_VOL_MODE);
        host_u.send(CMD_SOFT_RESET);
        `CHK({contrast, pend, ratio}, {6'h22, 1'b0, 3'h7})
        `CHK(ind_state, 2'h3)
        // Column save and restore around read-modify-write
        host_u.send(8'h10);
        host_u.send(8'h05);
        host_u.send(CMD_RMW_ENTER);
        host_u.rd();
        `CHK({rmw, col}, {1'b1, 8'h05})
        host_u.wr();
        host_u.wr();
        `CHK(col, 8'h07)
        host_u.send(CMD_RMW_END);
        `CHK({rmw, col}, {1'b0, 8'h05})
        // Test mode and software reset
        host_u.send(8'hf3);
        `CHK(tst, 1'b1)
        host_u.send(CMD_RMW_ENTER);
        host_u.send(CMD_SOFT_RESET);
        `CHK({tst, rmw, col, contrast}, {1'b0, 1'b0, 8'h00, 6'h20})
        `CHK({ratio, ind_state, ind_en}, {3'h0, 2'h0, 1'b0})
        `CHK(power, 3'h7)
        // Only the hard reset clears the supply field
        @(posedge i_ref_clk);
        #2 i_rst = 1'b1;
        @(posedge i_ref_clk);
        #2 i_rst = 1'b0;
        `CHK(power, 3'h0)
        host_u.send(CMD_VOL_MODE);
        host_u.send(8'hd5);
        `CHK(contrast, 6'h15)
        host_u.send(CMD_VOL_MODE);
        host_u.send(8'h20);
        `CHK(contrast, 6'h20)
        give_verdict();
    end
endmodule

bind lcdcd_decoder lcdcd_decoder_chk chk_u (.i_ref_clk, .i_rst, .i_cmd_valid, .i_cmd_byte,
    .i_data_rd, .o_col_addr, .o_com_reverse, .o_power_ctrl, .o_follower_on, .o_booster_on,
    .o_regulator_resistor_ratio, .o_contrast, .o_ind_enable, .o_ind_state, .o_rmw_mode,
    .o_test_mode, .o_cmd_pending);
